//--- rtl/audio_playback_unit.sv
// Purpose: Register set and sample fetch control of the audio playback unit
// Assumes: Register port and RAM read port are simple synchronous handshakes
// Notes: Conversion strobe divides the DAC clock (taken as clk) by 128
// Summary of operation
// [RULE1] Writing 1 to soft reset clears internal state, registers kept.
// [RULE2] Parameter bit 25 enables zero-cross detection on output samples.
// [RULE3] Parameter bit 16 selects which word half holds the first sample.
// [RULE4] Power-down bit 16 powers the DAC down; resets to powered down.
// [RULE5] Flags set on reaching threshold 1 or 2; software writes 0 to clear.
// [RULE6] Base address register holds fetch start of the first buffer.
// [RULE7] Register at 0x14 holds threshold 1, end of first buffer.
// [RULE8] Register at 0x18 holds threshold 2, end of second buffer.
// [RULE9] Read-only 0x1C shows the current fetch address; resets zero.
// [RULE10] Playback runs only while the run bit is set.
// [RULE11] Interrupt raised at the end of each of the two buffers.
// [RULE12] 7-bit counter strobes the DAC each 128 clocks.
// [RULE13] Software must set the enables before interrupts appear.
// [RULE14] Interrupt is flag and matching enable, bits 16 and 17.
// [RULE15] After the threshold 2 word, fetching wraps to the base address.
`timescale 1ns/100ps
`default_nettype none
module audio_playback_unit
  import playback_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset, active high
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_addr, // Register byte offset
  input wire logic [31:0] reg_wdata, // Register write data
  output logic [31:0] reg_rdata, // Register read data, valid the cycle after reg_rd
  output logic mem_req, // RAM read request
  output logic [31:0] mem_addr, // RAM read address
  input wire logic mem_ack, // RAM answer strobe
  input wire logic [31:0] mem_rdata, // RAM read data
  output logic [15:0] dac_data, // Sample to DAC
  output logic dac_strobe, // Conversion strobe, one cycle
  output logic dac_powerdown, // DAC power-down
  output logic irq // Interrupt
);
  logic [31:0] playback_ctrl;
  logic [31:0] audio_param_ctrl;
  logic [31:0] buffer_base_addr;
  logic [31:0] threshold_one_addr;
  logic [31:0] threshold_two_addr;
  logic [31:0] current_fetch_addr;
  logic thr_one_irq_enable;
  logic thr_two_irq_enable;
  logic thr_one_irq_flag;
  logic thr_two_irq_flag;
  logic soft_reset;
  logic run;
  fetch_state_t state;
  logic fetch_started;
  logic [STROBE_COUNT_WIDTH-1:0] strobe_count;
  logic half_sel;
  logic [15:0] last_sample;
  fetch_word_t buf_in;
  fetch_word_t buf_out;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_pop;
  logic tick;
  logic [15:0] first_half;
  logic [15:0] second_half;
  logic [15:0] next_sample;
  logic hit_one;
  logic hit_two;
  logic wr_hit;

  assign soft_reset = reg_wr && (reg_addr == OFF_PLAYBACK_CTRL)
                      && reg_wdata[SOFT_RESET_BIT_POS]; // RULE1
  assign run = playback_ctrl[RUN_BIT_POS];
  assign tick = (strobe_count == '1);
  assign buf_pop = tick && buf_out_valid && half_sel;
  assign hit_one = buf_pop && (buf_out.addr == threshold_one_addr);
  assign hit_two = buf_pop && (buf_out.addr == threshold_two_addr);

  // Register writes; soft reset bit is self-clearing
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      playback_ctrl <= PLAYBACK_CTRL_RESET;
      audio_param_ctrl <= AUDIO_PARAM_CTRL_RESET;
      dac_powerdown <= DAC_POWER_CTRL_RESET[DAC_POWERDOWN_BIT_POS]; // RULE4
      buffer_base_addr <= ADDR_RESET;
      threshold_one_addr <= ADDR_RESET;
      threshold_two_addr <= ADDR_RESET;
      thr_one_irq_enable <= 1'b0;
      thr_two_irq_enable <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFF_PLAYBACK_CTRL: playback_ctrl <= {31'h0, reg_wdata[RUN_BIT_POS]}; // RULE10
        OFF_AUDIO_PARAM_CTRL: audio_param_ctrl <= reg_wdata;
        OFF_DAC_POWER_CTRL: dac_powerdown <= reg_wdata[DAC_POWERDOWN_BIT_POS]; // RULE4
        OFF_THRESHOLD_IRQ_CTRL:
        begin
          thr_one_irq_enable <= reg_wdata[THR_ONE_EN_POS]; // RULE13
          thr_two_irq_enable <= reg_wdata[THR_TWO_EN_POS]; // RULE13
        end
        OFF_BUFFER_BASE_ADDR: buffer_base_addr <= reg_wdata; // RULE6
        OFF_THRESHOLD_ONE_ADDR: threshold_one_addr <= reg_wdata; // RULE7
        OFF_THRESHOLD_TWO_ADDR: threshold_two_addr <= reg_wdata; // RULE8
        default: ;
      endcase
    end
  end

  // Threshold flags: hardware set wins over software clear
  assign wr_hit = reg_wr && (reg_addr == OFF_THRESHOLD_IRQ_CTRL);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      thr_one_irq_flag <= 1'b0;
      thr_two_irq_flag <= 1'b0;
    end
    else
    begin
      if (hit_one)
      begin
        thr_one_irq_flag <= 1'b1; // RULE5 RULE11
      end
      else if (wr_hit && !reg_wdata[THR_ONE_FLAG_POS])
      begin
        thr_one_irq_flag <= 1'b0; // RULE5
      end
      if (hit_two)
      begin
        thr_two_irq_flag <= 1'b1; // RULE5 RULE11
      end
      else if (wr_hit && !reg_wdata[THR_TWO_FLAG_POS])
      begin
        thr_two_irq_flag <= 1'b0; // RULE5
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= (thr_one_irq_flag && thr_one_irq_enable)
             || (thr_two_irq_flag && thr_two_irq_enable); // RULE14
    end
  end

  // Register reads
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        OFF_PLAYBACK_CTRL: reg_rdata <= playback_ctrl;
        OFF_AUDIO_PARAM_CTRL: reg_rdata <= audio_param_ctrl;
        OFF_DAC_POWER_CTRL: reg_rdata <= 32'(dac_powerdown) << DAC_POWERDOWN_BIT_POS;
        OFF_THRESHOLD_IRQ_CTRL:
          reg_rdata <= (32'(thr_two_irq_enable) << THR_TWO_EN_POS)
                       | (32'(thr_one_irq_enable) << THR_ONE_EN_POS)
                       | (32'(thr_two_irq_flag) << THR_TWO_FLAG_POS)
                       | (32'(thr_one_irq_flag) << THR_ONE_FLAG_POS);
        OFF_BUFFER_BASE_ADDR: reg_rdata <= buffer_base_addr;
        OFF_THRESHOLD_ONE_ADDR: reg_rdata <= threshold_one_addr;
        OFF_THRESHOLD_TWO_ADDR: reg_rdata <= threshold_two_addr;
        OFF_CURRENT_FETCH_ADDR: reg_rdata <= current_fetch_addr; // RULE9
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Fetch engine: one word at a time into the buffer
  always_ff @(posedge clk)
  begin
    if (rst || soft_reset) // RULE1
    begin
      state <= FETCH_IDLE;
      mem_req <= 1'b0;
      mem_addr <= ADDR_RESET;
      current_fetch_addr <= ADDR_RESET; // RULE9
      fetch_started <= 1'b0;
    end
    else
    begin
      case (state)
        FETCH_IDLE:
        begin
          if (run && buf_in_ready) // RULE10
          begin
            mem_addr <= fetch_started ? current_fetch_addr : buffer_base_addr; // RULE6
            current_fetch_addr <= fetch_started ? current_fetch_addr : buffer_base_addr;
            fetch_started <= 1'b1;
            mem_req <= 1'b1;
            state <= FETCH_WAIT;
          end
        end
        FETCH_WAIT:
        begin
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            if (current_fetch_addr == threshold_two_addr)
            begin
              current_fetch_addr <= buffer_base_addr; // RULE15
            end
            else
            begin
              current_fetch_addr <= current_fetch_addr + WORD_STEP;
            end
            state <= FETCH_IDLE;
          end
        end
        default: state <= FETCH_IDLE;
      endcase
    end
  end

  assign buf_in.addr = current_fetch_addr;
  assign buf_in.data = mem_rdata;

  sample_buffer #(
    .WIDTH($bits(fetch_word_t))
  ) u_buffer (
    .clk(clk),
    .rst(rst),
    .flush(soft_reset),
    .in_valid((state == FETCH_WAIT) && mem_ack),
    .in_ready(buf_in_ready),
    .in_data(buf_in),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out)
  );

  // Sample order within a word
  always_comb
  begin
    if (audio_param_ctrl[SWAP_BIT_POS]) // RULE3
    begin
      first_half = buf_out.data[31:16];
      second_half = buf_out.data[15:0];
    end
    else
    begin
      first_half = buf_out.data[15:0];
      second_half = buf_out.data[31:16];
    end
    next_sample = half_sel ? second_half : first_half;
  end

  // Conversion timer
  always_ff @(posedge clk)
  begin
    if (rst || soft_reset || !run)
    begin
      strobe_count <= '0;
      dac_strobe <= 1'b0;
    end
    else
    begin
      strobe_count <= strobe_count + 1'b1; // RULE12
      dac_strobe <= tick; // RULE12
    end
  end

  // Output sample; zero-cross mode outputs zero for a sign change from a nonzero sample
  always_ff @(posedge clk)
  begin
    if (rst || soft_reset)
    begin
      half_sel <= 1'b0;
      last_sample <= 16'h0000;
      dac_data <= 16'h0000;
    end
    else if (tick && buf_out_valid && run)
    begin
      half_sel <= ~half_sel;
      last_sample <= next_sample;
      if (audio_param_ctrl[ZERO_CROSS_BIT_POS]
          && (next_sample[15] != last_sample[15]) && (last_sample != 16'h0000)) // RULE2
      begin
        dac_data <= 16'h0000;
      end
      else
      begin
        dac_data <= next_sample;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/playback_pkg.sv
// Purpose: Shared constants and types for the audio playback unit
// Assumes: 32-bit register port, word-aligned offsets
// Notes: Offsets are byte addresses
package playback_pkg;
  localparam logic [7:0] OFF_PLAYBACK_CTRL = 8'h00;
  localparam logic [7:0] OFF_AUDIO_PARAM_CTRL = 8'h04;
  localparam logic [7:0] OFF_DAC_POWER_CTRL = 8'h08;
  localparam logic [7:0] OFF_THRESHOLD_IRQ_CTRL = 8'h0c;
  localparam logic [7:0] OFF_BUFFER_BASE_ADDR = 8'h10;
  localparam logic [7:0] OFF_THRESHOLD_ONE_ADDR = 8'h14;
  localparam logic [7:0] OFF_THRESHOLD_TWO_ADDR = 8'h18;
  localparam logic [7:0] OFF_CURRENT_FETCH_ADDR = 8'h1c;
  localparam int RUN_BIT_POS = 0;
  localparam int SOFT_RESET_BIT_POS = 16;
  localparam int SWAP_BIT_POS = 16;
  localparam int ZERO_CROSS_BIT_POS = 25;
  localparam int DAC_POWERDOWN_BIT_POS = 16;
  localparam int THR_ONE_FLAG_POS = 0;
  localparam int THR_TWO_FLAG_POS = 1;
  localparam int THR_ONE_EN_POS = 16;
  localparam int THR_TWO_EN_POS = 17;
  localparam logic [31:0] PLAYBACK_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] AUDIO_PARAM_CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] DAC_POWER_CTRL_RESET = 32'h0001_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam int STROBE_COUNT_WIDTH = 7;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } fetch_word_t;
  typedef struct packed {
    logic valid;
    logic [15:0] sample;
  } dac_sample_t;
  typedef enum logic [1:0] {FETCH_IDLE, FETCH_REQ, FETCH_WAIT} fetch_state_t;
endpackage

//--- rtl/sample_buffer.sv
// Purpose: Two-entry valid/ready buffer for fetched words
// Assumes: Single clock, synchronous reset
// Notes: Flush empties the buffer in one cycle
`timescale 1ns/100ps
`default_nettype none
module sample_buffer #(
  parameter int WIDTH = 64
) (
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic flush, // Drop contents
  input wire logic in_valid, // Word offered
  output logic in_ready, // Space available
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word present
  input wire logic out_ready, // Consumer takes word
  output logic [WIDTH-1:0] out_data // Oldest word
);
  logic [WIDTH-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;
  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst || flush)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'd0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
      begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

//--- testbench/playback_assertions.sv
// Purpose: Port checks of the audio playback unit
// Assumes: Bound to audio_playback_unit
// Notes: Enables and base are shadowed from writes
`timescale 1ns/100ps
`default_nettype none
module playback_assertions
  import playback_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_addr, // Offset
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic mem_req, // RAM request
  input wire logic [31:0] mem_addr, // RAM address
  input wire logic mem_ack, // RAM answer
  input wire logic [31:0] mem_rdata, // RAM data
  input wire logic [15:0] dac_data, // Sample
  input wire logic dac_strobe, // Strobe
  input wire logic dac_powerdown, // Power-down
  input wire logic irq // Interrupt
);
  logic [1:0] en;
  logic [31:0] base;
  logic [31:0] last;
  logic [7:0] gap;
  logic armed;
  wire logic ctl_wr = reg_wr && reg_addr == OFF_PLAYBACK_CTRL;
  // A control write may restart the timer, so gap checks rearm after it
  always_ff @(posedge clk)
  begin
    en <= rst ? 2'h0 : (reg_wr && reg_addr == OFF_THRESHOLD_IRQ_CTRL) ? reg_wdata[17:16] : en;
    base <= rst ? 32'h0 : (reg_wr && reg_addr == OFF_BUFFER_BASE_ADDR) ? reg_wdata : base;
    last <= (mem_req && mem_ack) ? mem_addr : last;
    armed <= !rst && !ctl_wr && (armed || dac_strobe);
    gap <= (rst || dac_strobe || ctl_wr) ? 8'h0 : gap + 8'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_req_holds: assert property (
    mem_req && !mem_ack && !ctl_wr |=> mem_req && $stable(mem_addr))
    else $error("request dropped before answer");
  chk_ack_drops: assert property (mem_ack |=> !mem_req)
    else $error("request kept after answer");
  chk_addr_step: assert property (
    $rose(mem_req) |-> mem_addr == base || mem_addr == last + WORD_STEP)
    else $error("fetch address out of order");
  chk_strobe_gap: assert property (dac_strobe && armed |-> gap == 8'h7f)
    else $error("strobe spacing wrong");
  chk_strobe_pulse: assert property (dac_strobe |=> !dac_strobe)
    else $error("strobe longer than one cycle");
  chk_irq_enable: assert property (irq |-> $past(en) != 2'h0)
    else $error("interrupt without enable");
  chk_pd_set: assert property (
    reg_wr && reg_addr == OFF_DAC_POWER_CTRL && reg_wdata[DAC_POWERDOWN_BIT_POS] |=> dac_powerdown)
    else $error("power-down bit not set by write");
  chk_pd_clear: assert property (
    reg_wr && reg_addr == OFF_DAC_POWER_CTRL && !reg_wdata[DAC_POWERDOWN_BIT_POS] |=> !dac_powerdown)
    else $error("power-down bit not cleared by write");
  chk_reset_vals: assert property (
    disable iff (1'b0) rst |=> dac_powerdown && !irq && !mem_req && !dac_strobe
    && dac_data == 16'h0 && reg_rdata == 32'h0)
    else $error("outputs wrong after reset");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  cover property (dac_strobe && armed);
  cover property (irq);
  cover property ($rose(mem_req) && mem_addr == base && last != 32'h0);
endmodule
`default_nettype wire

//--- testbench/ram_model.sv
// Purpose: System RAM answering fetch requests
// Assumes: One request outstanding
// Notes: Word holds address low half and its inverse above
`timescale 1ns/100ps
`default_nettype none
module ram_model (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic mem_req, // Request
  input wire logic [31:0] mem_addr, // Address
  input wire logic [1:0] lag, // Wait cycles
  output logic mem_ack, // Answer
  output logic [31:0] mem_rdata // Data
);
  logic [1:0] cnt;
  // Outside an answer the data bus toggles so stale data never looks valid
  always_ff @(posedge clk)
  begin
    mem_ack <= !rst && mem_req && !mem_ack && cnt >= lag;
    mem_rdata <= (mem_req && !mem_ack && cnt >= lag) ? {~mem_addr[15:0], mem_addr[15:0]} : ~mem_rdata;
    cnt <= (rst || !mem_req || mem_ack || cnt >= lag) ? 2'h0 : cnt + 2'h1;
  end
endmodule
`default_nettype wire

//--- testbench/audio_playback_unit_regs_tb.sv
// Purpose: Self-checking bench of the audio playback unit
// Assumes: RAM model with random answer delay
// Notes: Two buffers of two words each, played twice per pass
`timescale 1ns/100ps
`default_nettype none
module audio_playback_unit_regs_tb import playback_pkg::*; ;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, collect = 1'b0;
  logic mem_req, mem_ack, dac_strobe, dac_powerdown, irq;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_addr, mem_rdata, rd, v, a;
  logic [15:0] dac_data, p, r;
  logic [1:0] lag = 2'h0;
  logic [15:0] exp_q[$];
  logic [31:0] rst_val [9] = '{PLAYBACK_CTRL_RESET, AUDIO_PARAM_CTRL_RESET, DAC_POWER_CTRL_RESET,
    32'h0, 32'h0, 32'h0, 32'h0, ADDR_RESET, 32'h0};
  logic [31:0] msk [8] = '{32'h0, '1, 32'h10000, 32'h30003, '1, '1, '1, '1};
  logic [31:0] keep [8] = '{32'h0, '1, 32'h10000, 32'h30000, '1, '1, '1, 32'h0};
  int error_cnt = 0, n_checks = 0, got = 0, seed = 32'hb582;
  audio_playback_unit audio_playback_unit_inst (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .dac_data(dac_data), .dac_strobe(dac_strobe), .dac_powerdown(dac_powerdown), .irq(irq));
  ram_model ram_model_inst (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr),
    .lag(lag), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] act);
    n_checks++;
    if (act !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, act);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    #5;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = ad;
    reg_wdata = d;
    @(posedge clk);
    #5;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd = reg_rdata;
  endtask
  task automatic results;
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
    forever #25 clk = ~clk;
  always @(posedge clk)
    #5 lag = 2'($random(seed));
  always @(posedge clk)
    if (collect && dac_strobe === 1'b1)
    begin
      check("dac_data", 32'(exp_q.pop_front()), 32'(dac_data));
      got++;
    end
  initial
  begin
    repeat (16) @(posedge clk);
    #5;
    rst = 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      acc(1'b0, 8'(i * 4), 32'h0);
      check("reset value", rst_val[i], rd);
    end
    check("dac_powerdown", 32'h1, {31'h0, dac_powerdown});
    for (int i = 1; i < 8; i++)
    begin
      v = $random(seed);
      acc(1'b1, 8'(i * 4), v);
      acc(1'b0, 8'(i * 4), 32'h0);
      check("readback", v & keep[i], rd & msk[i]);
    end
    acc(1'b1, OFF_BUFFER_BASE_ADDR, 32'h100);
    acc(1'b1, OFF_THRESHOLD_ONE_ADDR, 32'h104);
    acc(1'b1, OFF_THRESHOLD_TWO_ADDR, 32'h10c);
    acc(1'b1, OFF_DAC_POWER_CTRL, 32'h0);
    for (int s = 0; s < 3; s++)
    begin
      acc(1'b1, OFF_THRESHOLD_IRQ_CTRL, s ? 32'h30000 : 32'h0);
      acc(1'b1, OFF_AUDIO_PARAM_CTRL, (s == 2) ? 32'h2000000 : (s == 1) ? 32'h10000 : 32'h0);
      acc(1'b1, OFF_PLAYBACK_CTRL, 32'h10000);
      acc(1'b0, OFF_BUFFER_BASE_ADDR, 32'h0);
      check("base kept", 32'h100, rd);
      p = 16'h0;
      for (int i = 0; i < 16; i++)
      begin
        a = 32'h100 + 4 * ((i / 2) % 4);
        r = ((i % 2) != (s == 1)) ? ~a[15:0] : a[15:0];
        // Zero-cross mode mutes a sign change that does not pass through zero
        exp_q.push_back((s == 2 && p != 16'h0 && r[15] != p[15]) ? 16'h0 : r);
        p = r;
      end
      got = 0;
      collect = 1'b1;
      acc(1'b1, OFF_PLAYBACK_CTRL, 32'h1);
      for (int t = 0; t < 3000 && got < 16; t++)
        @(posedge clk);
      collect = 1'b0;
      check("samples", 32'd16, 32'(got));
      if (got < 16)
        results();
      acc(1'b1, OFF_PLAYBACK_CTRL, 32'h0);
      acc(1'b0, OFF_THRESHOLD_IRQ_CTRL, 32'h0);
      check("flags", s ? 32'h30003 : 32'h3, rd & 32'h30003);
      check("irq", 32'(s != 0), {31'h0, irq});
      acc(1'b0, OFF_CURRENT_FETCH_ADDR, 32'h0);
      check("fetch addr", 32'h10, rd >> 4);
      acc(1'b1, OFF_THRESHOLD_IRQ_CTRL, 32'h30000);
      acc(1'b0, OFF_THRESHOLD_IRQ_CTRL, 32'h0);
      check("cleared", 32'h30000, rd & 32'h30003);
      check("irq off", 32'h0, {31'h0, irq});
    end
    results();
  end
endmodule
bind audio_playback_unit playback_assertions playback_assertions_inst (.clk(clk), .rst(rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .dac_data(dac_data), .dac_strobe(dac_strobe),
  .dac_powerdown(dac_powerdown), .irq(irq));
`default_nettype wire
